// ---- hdl/crcfs_params.svh ----
// constants of the crc fifo serial shifter: offsets, fields, reset values
`ifndef CRCFS_PARAMS_SVH
`define CRCFS_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CRCFS_OFS_CTRL      4'h0
`define CRCFS_OFS_POLY      4'h1
`define CRCFS_OFS_DATA      4'h2
`define CRCFS_OFS_RESULT    4'h3
`define CRCFS_OFS_STATUS    4'h4
`define CRCFS_OFS_IRQ_STAT  4'h5
`define CRCFS_OFS_IRQ_MASK  4'h6

// ----------------------------------------
// control field positions
// ----------------------------------------
`define CRCFS_CTRL_GO       0
`define CRCFS_CTRL_IDLE_STOP 1
`define CRCFS_CTRL_POLY_LENGTH_LO  4
`define CRCFS_CTRL_POLY_LENGTH_HI  7

// ----------------------------------------
// status field positions
// ----------------------------------------
`define CRCFS_STAT_VWC_LO   0
`define CRCFS_STAT_VWC_HI   4
`define CRCFS_STAT_FULL     5
`define CRCFS_STAT_EMPTY    6

// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define CRCFS_POLY_LENGTH_SPLIT    4'h7
`define CRCFS_DEPTH_WIDE    5'h08
`define CRCFS_DEPTH_NARROW  5'h10
`define CRCFS_IRQ_DONE_BIT  0
`define CRCFS_RST_POLY_LENGTH      4'hf
`define CRCFS_RST_POLY      16'h0000

`endif

// ---- hdl/crcfs_pkg.sv ----
// types shared by the crc fifo serial shifter
package crcfs_pkg;

    typedef enum logic [1:0] {
        CRCFS_ST_IDLE  = 2'b01,
        CRCFS_ST_SHIFT = 2'b10
    } crcfs_state_type;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } crcfs_bus_req_type;

    typedef struct packed {
        crcfs_state_type fsm;
        logic            go;
        logic            idle_stop;
        logic [3:0]      poly_length;
        logic [15:0]     poly;
        logic [15:0]     crc;
        logic [15:0]     mem_0;
        logic [15:0]     mem_1;
        logic [15:0]     mem_2;
        logic [15:0]     mem_3;
        logic [15:0]     mem_4;
        logic [15:0]     mem_5;
        logic [15:0]     mem_6;
        logic [15:0]     mem_7;
        logic [15:0]     mem_8;
        logic [15:0]     mem_9;
        logic [15:0]     mem_10;
        logic [15:0]     mem_11;
        logic [15:0]     mem_12;
        logic [15:0]     mem_13;
        logic [15:0]     mem_14;
        logic [15:0]     mem_15;
        logic [3:0]      wr_ptr;
        logic [3:0]      rd_ptr;
        logic [4:0]      valid_word_count;
        logic [3:0]      bit_idx;
        logic            fifo_full_flag;
        logic            fifo_empty_flag;
        logic [0:0]      irq_stat;
        logic [0:0]      irq_mask;
        logic            irq;
        logic [15:0]     rdata;
    } crcfs_state_rec_type;

endpackage : crcfs_pkg

// ---- hdl/crcfs_top.sv ----
// crc fifo serial shifter: word fifo, bit serial crc engine, register port
//
// Operation
// - serial shifting begins only after software writes one to go.
// - fifo depth is 8 when poly_length exceeds 7, else 16.
// - entries poly_length+1 bits (1 to 16); payload low bits, upper bits ignored.
// - writing the data port increments the five-bit valid_word_count by one.
// - shifter runs while go and count nonzero; decrements per word; stops at 0.
// - one bit per clock, so (poly_length+1) times count cycles.
// - fifo_full_flag set when count reaches depth 8 or 16.
// - fifo_empty_flag set when count reaches 0.
// - write while full wraps count to 0, acts empty, no interrupt.
// - interrupt when valid_word_count goes from 1 to 0.
// - in sleep the module freezes its state and resumes afterwards.
// - in idle it runs unless idle_stop, then freezes as in sleep; no interrupt is set while frozen.
`timescale 1ns/100ps
`include "crcfs_params.svh"

module crcfs_top #(
    parameter int DATA_W = 16
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        sleep_in,
    input  wire logic        idle_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [15:0]      rdata_out,
    output logic             irq_out,
    output logic             fifo_full_out,
    output logic             fifo_empty_out
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (DATA_W != 16) begin : g_bad_width
        $error("crcfs_top: only a 16-bit data path is supported");
    end

    crcfs_pkg::crcfs_state_rec_type s_q;
    crcfs_pkg::crcfs_state_rec_type s_d;
    crcfs_pkg::crcfs_bus_req_type   req;
    logic [15:0]                    mem [16];
    logic                           frozen;
    logic [4:0]                     depth;
    logic [15:0]                    cur_word;
    logic                           in_bit;
    logic                           fb;
    logic                           word_done;
    logic                           shifting;
    logic                           pushing;
    logic [4:0]                     cnt_next;
    logic [0:0]                     ev;

    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    // ----------------------------------------
    // fifo storage view
    // ----------------------------------------
    assign mem[0]  = s_q.mem_0;
    assign mem[1]  = s_q.mem_1;
    assign mem[2]  = s_q.mem_2;
    assign mem[3]  = s_q.mem_3;
    assign mem[4]  = s_q.mem_4;
    assign mem[5]  = s_q.mem_5;
    assign mem[6]  = s_q.mem_6;
    assign mem[7]  = s_q.mem_7;
    assign mem[8]  = s_q.mem_8;
    assign mem[9]  = s_q.mem_9;
    assign mem[10] = s_q.mem_10;
    assign mem[11] = s_q.mem_11;
    assign mem[12] = s_q.mem_12;
    assign mem[13] = s_q.mem_13;
    assign mem[14] = s_q.mem_14;
    assign mem[15] = s_q.mem_15;

    // ----------------------------------------
    // datapath terms
    // ----------------------------------------
    // idle freezes only with idle_stop set; sleep always freezes
    assign frozen = sleep_in | (idle_in & s_q.idle_stop);
    assign depth  = (s_q.poly_length > `CRCFS_POLY_LENGTH_SPLIT) ? `CRCFS_DEPTH_WIDE
                                                          : `CRCFS_DEPTH_NARROW;
    assign cur_word = mem[s_q.rd_ptr];
    // msb first: bit index counts down from poly_length
    assign in_bit   = cur_word[s_q.bit_idx];
    assign fb       = in_bit ^ s_q.crc[s_q.poly_length];
    assign shifting = !frozen && s_q.go && (s_q.valid_word_count != 5'h00)
                      && (s_q.fsm == crcfs_pkg::CRCFS_ST_SHIFT);
    assign word_done = shifting && (s_q.bit_idx == 4'h0);
    assign pushing   = !frozen && req.wr && (req.addr == `CRCFS_OFS_DATA);

    always_comb begin
        cnt_next = s_q.valid_word_count;
        ev       = 1'b0;
        if (pushing && s_q.fifo_full_flag) begin
            // a write into a full fifo wraps the count with no event
            cnt_next = 5'h00;
        end else if (pushing && !word_done) begin
            cnt_next = s_q.valid_word_count + 5'h01;
        end else if (!pushing && word_done) begin
            cnt_next = s_q.valid_word_count - 5'h01;
            ev       = (s_q.valid_word_count == 5'h01);
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rdata = 16'h0000;

        // register reads are served even while frozen
        if (req.rd) begin
            case (req.addr)
                `CRCFS_OFS_CTRL: begin
                    s_d.rdata = {8'h00, s_q.poly_length, 2'b00, s_q.idle_stop, s_q.go};
                end
                `CRCFS_OFS_POLY:     s_d.rdata = s_q.poly;
                `CRCFS_OFS_DATA,
                `CRCFS_OFS_RESULT:   s_d.rdata = s_q.crc;
                `CRCFS_OFS_STATUS: begin
                    s_d.rdata = {9'h000, s_q.fifo_empty_flag, s_q.fifo_full_flag, s_q.valid_word_count};
                end
                `CRCFS_OFS_IRQ_STAT: s_d.rdata = {15'h0000, s_q.irq_stat};
                `CRCFS_OFS_IRQ_MASK: s_d.rdata = {15'h0000, s_q.irq_mask};
                default:             s_d.rdata = 16'h0000;
            endcase
        end

        if (!frozen) begin
            if (req.wr) begin
                case (req.addr)
                    `CRCFS_OFS_CTRL: begin
                        s_d.go          = req.wdata[`CRCFS_CTRL_GO];
                        s_d.idle_stop   = req.wdata[`CRCFS_CTRL_IDLE_STOP];
                        s_d.poly_length = req.wdata[`CRCFS_CTRL_POLY_LENGTH_HI:`CRCFS_CTRL_POLY_LENGTH_LO];
                    end
                    `CRCFS_OFS_POLY:     s_d.poly = req.wdata;
                    `CRCFS_OFS_RESULT:   s_d.crc  = req.wdata;
                    `CRCFS_OFS_IRQ_MASK: s_d.irq_mask = req.wdata[0:0];
                    default: begin
                    end
                endcase
            end

            if (pushing) begin
                case (s_q.wr_ptr)
                    4'h0: s_d.mem_0  = req.wdata;
                    4'h1: s_d.mem_1  = req.wdata;
                    4'h2: s_d.mem_2  = req.wdata;
                    4'h3: s_d.mem_3  = req.wdata;
                    4'h4: s_d.mem_4  = req.wdata;
                    4'h5: s_d.mem_5  = req.wdata;
                    4'h6: s_d.mem_6  = req.wdata;
                    4'h7: s_d.mem_7  = req.wdata;
                    4'h8: s_d.mem_8  = req.wdata;
                    4'h9: s_d.mem_9  = req.wdata;
                    4'ha: s_d.mem_10 = req.wdata;
                    4'hb: s_d.mem_11 = req.wdata;
                    4'hc: s_d.mem_12 = req.wdata;
                    4'hd: s_d.mem_13 = req.wdata;
                    4'he: s_d.mem_14 = req.wdata;
                    default: s_d.mem_15 = req.wdata;
                endcase
                if (s_q.fifo_full_flag) begin
                    // wrap: drop everything, behave as empty
                    s_d.wr_ptr = 4'h0;
                    s_d.rd_ptr = 4'h0;
                    s_d.bit_idx = s_q.poly_length;
                end else begin
                    s_d.wr_ptr = (s_q.wr_ptr + 4'h1) & (depth[3:0] - 4'h1 | {depth[4], 3'h0});
                end
            end

            case (s_q.fsm)
                crcfs_pkg::CRCFS_ST_IDLE: begin
                    s_d.bit_idx = s_q.poly_length;
                    if (s_q.go && s_q.valid_word_count != 5'h00) begin
                        s_d.fsm = crcfs_pkg::CRCFS_ST_SHIFT;
                    end
                end
                crcfs_pkg::CRCFS_ST_SHIFT: begin
                    if (shifting && !(pushing && s_q.fifo_full_flag)) begin
                        // galois lfsr, taps from poly masked to poly_length+1 bits
                        s_d.crc = ({s_q.crc[14:0], 1'b0} ^ (fb ? s_q.poly : 16'h0000))
                                  & ~(16'hfffe << s_q.poly_length);
                        if (word_done) begin
                            s_d.bit_idx = s_q.poly_length;
                            s_d.rd_ptr  = (s_q.rd_ptr + 4'h1) & (depth[3:0] - 4'h1 | {depth[4], 3'h0});
                        end else begin
                            s_d.bit_idx = s_q.bit_idx - 4'h1;
                        end
                    end
                    if (!s_q.go || cnt_next == 5'h00) begin
                        s_d.fsm = crcfs_pkg::CRCFS_ST_IDLE;
                    end
                end
                default: s_d.fsm = crcfs_pkg::CRCFS_ST_IDLE;
            endcase

            s_d.valid_word_count = cnt_next;
            s_d.fifo_full_flag   = (cnt_next == depth);
            s_d.fifo_empty_flag  = (cnt_next == 5'h00);
        end

        // w1c clears still pass while frozen, events are set only when not frozen; set wins over clear
        if (req.wr && req.addr == `CRCFS_OFS_IRQ_STAT) begin
            s_d.irq_stat = s_q.irq_stat & ~req.wdata[0:0];
        end
        if (!frozen) begin
            s_d.irq_stat = s_d.irq_stat | ev;
        end
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
            s_q.fsm             <= crcfs_pkg::CRCFS_ST_IDLE;
            s_q.poly_length     <= `CRCFS_RST_POLY_LENGTH;
            s_q.poly            <= `CRCFS_RST_POLY;
            s_q.bit_idx         <= `CRCFS_RST_POLY_LENGTH;
            s_q.fifo_empty_flag <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_out      = s_q.rdata;
    assign irq_out        = s_q.irq;
    assign fifo_full_out  = s_q.fifo_full_flag;
    assign fifo_empty_out = s_q.fifo_empty_flag;

endmodule : crcfs_top

// ---- tb/crcfs_checker.sv ----
// port assertions for the crc fifo serial shifter
`timescale 1ns/100ps
`include "crcfs_params.svh"
module crcfs_checker (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        sleep_in,
    input wire logic        idle_in,
    input wire logic [3:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic        irq_out,
    input wire logic        fifo_full_out,
    input wire logic        fifo_empty_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    flags_exclusive_a: assert property (!(fifo_full_out && fifo_empty_out))
        else $error("full and empty together");
    empty_leaves_a: assert property ($fell(fifo_empty_out) |-> $past(wr_in) || $past(wr_in, 2))
        else $error("empty cleared without a write");
    full_rises_a: assert property ($rose(fifo_full_out) |-> $past(wr_in) || $past(wr_in, 2))
        else $error("full set without a write");
    empty_holds_a: assert property (fifo_empty_out && !wr_in && !$past(wr_in) |=> fifo_empty_out)
        else $error("empty dropped while idle");
    wrap_empty_a: assert property (wr_in && addr_in == `CRCFS_OFS_DATA && fifo_full_out && !sleep_in && !idle_in
        |-> ##[1:2] fifo_empty_out) else $error("write when full did not empty");
    irq_cause_a: assert property ($rose(irq_out) |-> fifo_empty_out || $past(wr_in) || $past(wr_in, 2))
        else $error("irq rose without cause");
    sleep_freeze_a: assert property (sleep_in && $past(sleep_in) && $past(sleep_in, 2)
        |-> $stable(fifo_empty_out) && $stable(fifo_full_out)) else $error("flags moved asleep");
    rdata_quiet_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside read slot");
    irq_cov_c: cover property ($rose(irq_out));
    full_cov_c: cover property ($rose(fifo_full_out));
    sleep_cov_c: cover property (sleep_in && !fifo_empty_out);
endmodule : crcfs_checker

bind crcfs_top crcfs_checker u_crcfs_checker (.clk_in(clk_in), .rst_in(rst_in), .sleep_in(sleep_in),
    .idle_in(idle_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .fifo_full_out(fifo_full_out), .fifo_empty_out(fifo_empty_out));

// ---- tb/tb_top.sv ----
// register level testbench for the crc fifo serial shifter
`timescale 1ns/100ps
`include "crcfs_params.svh"
module tb_top;
    logic        clk_in, rst_in, sleep_in, idle_in, wr_in, rd_in;
    logic [3:0]  addr_in;
    logic [15:0] wdata_in, rdata_out, crc_exp;
    logic [15:0] msg_words [3] = '{16'h12a5, 16'hff3c, 16'h00ff};
    logic        irq_out, fifo_full_out, fifo_empty_out;
    int          bad_count, n_compared, cycles, n;

    crcfs_top u_crcfs_top (.clk_in(clk_in), .rst_in(rst_in), .sleep_in(sleep_in), .idle_in(idle_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .irq_out(irq_out), .fifo_full_out(fifo_full_out), .fifo_empty_out(fifo_empty_out));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    // hang guard, the whole run needs well under 2000 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk16

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        rd_in <= 1'b1; addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk16(rdata_out, exp);
    endtask : rd_chk

    task automatic wait_empty(input int lim);
        n = 0;
        do begin
            @(posedge clk_in);
            #1 n++;
        end while (fifo_empty_out !== 1'b1 && n < lim);
    endtask : wait_empty

    // reference galois step, msb of the valid payload first
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [15:0] w, input int pl,
                                            input logic [15:0] p);
        logic [15:0] m;
        m = (16'h0001 << (pl + 1)) - 16'h0001;
        for (int i = pl; i >= 0; i--) c = ((c << 1) ^ ((w[i] ^ c[pl]) ? p : 16'h0000)) & m;
        return c;
    endfunction : crc_upd

    initial begin
        {sleep_in, idle_in, wr_in, rd_in, addr_in, wdata_in} = '0;
        rst_in = 1'b1;
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_chk(`CRCFS_OFS_STATUS, 16'h0040);
        rd_chk(`CRCFS_OFS_CTRL, 16'h00f0);
        rd_chk(4'hf, 16'h0000);
        $display("test reset done");
        // upper byte is junk and must not reach the crc
        wr_reg(`CRCFS_OFS_CTRL, 16'h0070);
        wr_reg(`CRCFS_OFS_POLY, 16'h0007);
        rd_chk(`CRCFS_OFS_POLY, 16'h0007);
        wr_reg(`CRCFS_OFS_RESULT, 16'h0000);
        crc_exp = 16'h0000;
        foreach (msg_words[i]) begin
            wr_reg(`CRCFS_OFS_DATA, msg_words[i]);
            crc_exp = crc_upd(crc_exp, msg_words[i], 7, 16'h0007);
        end
        rd_chk(`CRCFS_OFS_STATUS, 16'h0003);
        repeat (20) @(posedge clk_in);
        rd_chk(`CRCFS_OFS_STATUS, 16'h0003);
        wr_reg(`CRCFS_OFS_IRQ_MASK, 16'h0001);
        rd_chk(`CRCFS_OFS_IRQ_MASK, 16'h0001);
        wr_reg(`CRCFS_OFS_CTRL, 16'h0071);
        wait_empty(100);
        // one cycle to enter shifting, then 3 words of 8 bits
        chk16(16'(n), 16'h0019);
        rd_chk(`CRCFS_OFS_DATA, crc_exp);
        rd_chk(`CRCFS_OFS_RESULT, crc_exp);
        rd_chk(`CRCFS_OFS_IRQ_STAT, 16'h0001);
        chk16(16'(irq_out), 16'h0001);
        wr_reg(`CRCFS_OFS_IRQ_MASK, 16'h0000);
        repeat (2) @(posedge clk_in);
        #1 chk16(16'(irq_out), 16'h0000);
        wr_reg(`CRCFS_OFS_IRQ_MASK, 16'h0001);
        wr_reg(`CRCFS_OFS_IRQ_STAT, 16'h0001);
        rd_chk(`CRCFS_OFS_IRQ_STAT, 16'h0000);
        chk16(16'(irq_out), 16'h0000);
        $display("test shift done");
        // freeze mid word: mode 0 sleep, mode 1 idle with idle_stop set
        for (int md = 0; md < 2; md++) begin
            wr_reg(`CRCFS_OFS_CTRL, md ? 16'h0073 : 16'h0071);
            wr_reg(`CRCFS_OFS_DATA, 16'h005a);
            // two bits go in first so the freeze lands mid word
            repeat (3) @(posedge clk_in);
            if (md) idle_in <= 1'b1;
            else sleep_in <= 1'b1;
            repeat (30) @(posedge clk_in);
            {sleep_in, idle_in} <= 2'b00;
            #1 chk16(16'(fifo_empty_out), 16'h0000);
            wait_empty(20);
            chk16(16'(fifo_empty_out), 16'h0001);
            crc_exp = crc_upd(crc_exp, 16'h005a, 7, 16'h0007);
            rd_chk(`CRCFS_OFS_DATA, crc_exp);
        end
        // idle_stop must be cleared before idle is entered, else the write is lost
        wr_reg(`CRCFS_OFS_CTRL, 16'h0071);
        idle_in <= 1'b1;
        wr_reg(`CRCFS_OFS_DATA, 16'h0011);
        wait_empty(20);
        chk16(16'(fifo_empty_out), 16'h0001);
        crc_exp = crc_upd(crc_exp, 16'h0011, 7, 16'h0007);
        rd_chk(`CRCFS_OFS_DATA, crc_exp);
        @(posedge clk_in);
        idle_in <= 1'b0;
        $display("test freeze done");
        // depth per length, then a write when full wraps with no irq
        for (int k = 0; k < 2; k++) begin
            wr_reg(`CRCFS_OFS_CTRL, k ? 16'h00f0 : 16'h0070);
            wr_reg(`CRCFS_OFS_IRQ_STAT, 16'h0001);
            repeat ((k ? 8 : 16) - 1) wr_reg(`CRCFS_OFS_DATA, 16'h00c3);
            repeat (2) @(posedge clk_in);
            #1 chk16(16'(fifo_full_out), 16'h0000);
            wr_reg(`CRCFS_OFS_DATA, 16'h00c3);
            rd_chk(`CRCFS_OFS_STATUS, k ? 16'h0028 : 16'h0030);
            wr_reg(`CRCFS_OFS_DATA, 16'h00c3);
            rd_chk(`CRCFS_OFS_STATUS, 16'h0040);
            rd_chk(`CRCFS_OFS_IRQ_STAT, 16'h0000);
        end
        $display("test full done");
        close_out();
    end
endmodule : tb_top
